// ==== core/delay_qualifier.sv ====
// on/off qualification delay for one relay
`timescale 1ns/1ps

module delay_qualifier #(
	parameter int DW = 10
) (
	// clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// timing
	input  wire logic          tick,
	// request
	input  wire logic          zone_valid,
	input  wire logic          want_on,
	input  wire logic          hold,
	input  wire logic [DW-1:0] on_delay,
	input  wire logic [DW-1:0] off_delay,
	// result
	output logic               state_q
);

	logic [DW-1:0] cnt_q;
	logic          pending;
	logic [DW-1:0] delay;

	assign pending = zone_valid && (want_on != state_q) && !hold;
	assign delay   = want_on ? on_delay : off_delay;

	// leaving the zone early drops the pending change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (!pending) begin
			cnt_q <= '0;
		end else if (tick && cnt_q != {DW{1'b1}}) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// zero delay commits in the first pending cycle; the tick runs free,
	// so the first count may be short and one extra tick is waited
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= 1'b0;
		end else if (pending && (delay == '0 || cnt_q > delay)) begin
			state_q <= want_on;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_QUAL_HOLD: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!pending |=> $stable(state_q))
		else $error("relay state changed with nothing pending");

	AST_QUAL_WAIT: assert property (@(posedge hclk)
		disable iff (!hresetn)
		pending && delay != '0 && cnt_q <= delay |=> $stable(state_q))
		else $error("relay state changed before its delay ran out");

endmodule : delay_qualifier

// ==== core/peak_hold_relay_threshold_ctrl.sv ====
// peak hold and threshold relay controller with AHB-Lite registers
// ----------------------------------------
// ----------------------------------------
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "relay_defs.svh"

module peak_hold_relay_threshold_ctrl #(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int DW          = 10
) (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// measurement stage
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] sample_value,
	input  wire logic               out_of_range,
	// relay and indicator
	output logic                    relay_drive,
	output logic                    relay_led,
	output logic                    peak_showing,
	output logic signed [15:0]      shown_value
);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [31:0]        ctrl_q;
	logic signed [15:0] thr1_q;
	logic signed [15:0] thr2_q;
	logic [DW-1:0]      band_halfwidth_q;
	logic [DW-1:0]      on_dly_q;
	logic [DW-1:0]      off_dly_q;
	logic [15:0]        swing_q;
	logic [15:0]        show_per_q;
	logic               wr_pend_q;
	logic [7:0]         wr_addr_q;
	logic [31:0]        rd_q;
	logic [31:0]        rd_d;
	logic [31:0]        status;
	logic               addr_ok;
	logic signed [15:0] peak_q;
	logic               relay_q;
	logic               fault;
	logic               zone_a_q;

	assign addr_ok   = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rd_q;

	always_comb begin
		unique case (haddr[7:0])
			`OFS_CTRL:   rd_d = ctrl_q;
			`OFS_THR1:   rd_d = {{16{thr1_q[15]}}, thr1_q};
			`OFS_THR2:   rd_d = {{16{thr2_q[15]}}, thr2_q};
			`OFS_BAND_HALFWIDTH:   rd_d = {{(32-DW){1'b0}}, band_halfwidth_q};
			`OFS_DELAY:  rd_d = {{(16-DW){1'b0}}, off_dly_q,
			                     {(16-DW){1'b0}}, on_dly_q};
			`OFS_SWING:  rd_d = {16'h0000, swing_q};
			`OFS_SHOW:   rd_d = {16'h0000, show_per_q};
			`OFS_STATUS: rd_d = status;
			`OFS_PEAK:   rd_d = {{16{peak_q[15]}}, peak_q};
			`OFS_SHOWN:  rd_d = {{16{shown_value[15]}}, shown_value};
			default:     rd_d = 32'h0000_0000;
		endcase
	end

	// read data registered in the address phase: zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= `RST_CTRL;
			thr1_q     <= `RST_THR;
			thr2_q     <= `RST_THR;
			band_halfwidth_q     <= `RST_BAND_HALFWIDTH;
			on_dly_q   <= `RST_DELAY;
			off_dly_q  <= `RST_DELAY;
			swing_q    <= `RST_SWING;
			show_per_q <= `RST_SHOW;
		end else if (wr_pend_q) begin
			unique case (wr_addr_q)
				`OFS_CTRL:  ctrl_q <= {23'h000000, hwdata[8:0]};
				`OFS_THR1:  thr1_q <= hwdata[15:0];
				`OFS_THR2:  thr2_q <= hwdata[15:0];
				`OFS_BAND_HALFWIDTH:  band_halfwidth_q <= hwdata[DW-1:0];
				`OFS_DELAY: begin
					on_dly_q  <= hwdata[DW-1:0];
					off_dly_q <= hwdata[`DLY_OFF_LSB +: DW];
				end
				`OFS_SWING: swing_q    <= hwdata[15:0];
				`OFS_SHOW:  show_per_q <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	relay_pkg::relay_mode_e mode;
	relay_pkg::fault_resp_e fresp;
	logic                   use_peak;
	logic                   unit_min;
	logic                   remote_cmd;
	logic                   fitted;

	assign mode       = relay_pkg::relay_mode_e'(
	                    ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	assign fresp      = relay_pkg::fault_resp_e'(
	                    ctrl_q[`CTRL_FAULT_MSB:`CTRL_FAULT_LSB]);
	assign use_peak   = ctrl_q[`CTRL_PEAK_BIT];
	assign unit_min   = ctrl_q[`CTRL_MIN_BIT];
	assign remote_cmd = ctrl_q[`CTRL_CMD_BIT];
	assign fitted     = ctrl_q[`CTRL_FIT_BIT];

	// ----------------------------------------
	// time base: tenth of second, tenth of minute
	// ----------------------------------------
	logic [31:0] pre_q;
	logic [5:0]  min_q;
	logic        tick_s;
	logic        tick_m;
	logic        tick;

	assign tick_s = (pre_q == 32'(TICK_CYCLES - 1));
	assign tick_m = tick_s && (min_q == 6'(`TENTHS_PER_MIN - 1));
	assign tick   = unit_min ? tick_m : tick_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 32'h0000_0000;
		end else begin
			pre_q <= tick_s ? 32'h0000_0000 : pre_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			min_q <= 6'h00;
		end else if (tick_m) begin
			min_q <= 6'h00;
		end else if (tick_s) begin
			min_q <= min_q + 6'h01;
		end
	end

	// ----------------------------------------
	// peak detector and hold
	// ----------------------------------------
	relay_pkg::peak_state_e pk_q;
	logic signed [15:0]     lo_q;
	logic signed [15:0]     hi_q;
	logic signed [17:0]     rise;
	logic signed [17:0]     fall;
	logic                   peak_found;
	logic                   showing_q;
	logic [15:0]            show_cnt_q;

	assign rise = 18'(sample_value) - 18'(lo_q);
	assign fall = 18'(hi_q) - 18'(sample_value);
	assign peak_found = sample_valid && pk_q == relay_pkg::PK_FALL
	                    && fall >= $signed({2'b00, swing_q});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pk_q <= relay_pkg::PK_RISE;
			lo_q <= 16'h0000;
			hi_q <= 16'h0000;
		end else if (sample_valid) begin
			unique case (pk_q)
				relay_pkg::PK_RISE: begin
					if (rise >= $signed({2'b00, swing_q})) begin
						pk_q <= relay_pkg::PK_FALL;
						hi_q <= sample_value;
					end else if (sample_value < lo_q) begin
						lo_q <= sample_value;
					end
				end
				relay_pkg::PK_FALL: begin
					if (peak_found) begin
						pk_q <= relay_pkg::PK_RISE;
						lo_q <= sample_value;
					end else if (sample_value > hi_q) begin
						hi_q <= sample_value;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			peak_q <= 16'h0000;
		end else if (peak_found) begin
			peak_q <= hi_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			showing_q  <= 1'b0;
			show_cnt_q <= 16'h0000;
		end else if (peak_found) begin
			showing_q  <= 1'b1;
			show_cnt_q <= 16'h0000;
		end else if (showing_q && show_cnt_q >= show_per_q) begin
			showing_q <= 1'b0;
		end else if (showing_q && tick_s) begin
			show_cnt_q <= show_cnt_q + 16'h0001;
		end
	end

	assign peak_showing = showing_q;
	assign shown_value  = showing_q ? peak_q : sample_value;

	// ----------------------------------------
	// zone evaluation, once per sample
	// ----------------------------------------
	logic signed [15:0] cmp;
	logic signed [15:0] t_lo;
	logic signed [15:0] t_hi;
	logic signed [17:0] h;
	logic signed [17:0] v;
	logic               above;
	logic               below;
	logic               dual_a;
	logic               dual_b;
	logic               dual;
	logic               zone_valid_q;
	logic               want_on_q;
	logic               qual_state;

	assign cmp  = use_peak ? shown_value : sample_value;
	assign t_lo = (thr1_q < thr2_q) ? thr1_q : thr2_q;
	assign t_hi = (thr1_q < thr2_q) ? thr2_q : thr1_q;
	assign h    = $signed({{(18-DW){1'b0}}, band_halfwidth_q});
	assign v    = 18'(cmp);
	assign above  = v > 18'(thr1_q) + h;
	assign below  = v < 18'(thr1_q) - h;
	assign dual_a = v > 18'(t_lo) + h && v < 18'(t_hi) - h;
	assign dual_b = v > 18'(t_hi) + h || v < 18'(t_lo) - h;
	assign dual   = mode == relay_pkg::MODE_IN
	                || mode == relay_pkg::MODE_OUT;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zone_valid_q <= 1'b0;
			want_on_q    <= 1'b0;
			zone_a_q     <= 1'b0;
		end else if (sample_valid) begin
			zone_a_q <= dual ? dual_a : above;
			unique case (mode)
				relay_pkg::MODE_ON: begin
					zone_valid_q <= above || below;
					want_on_q    <= above;
				end
				relay_pkg::MODE_OFF: begin
					zone_valid_q <= above || below;
					want_on_q    <= below;
				end
				relay_pkg::MODE_IN: begin
					zone_valid_q <= dual_a || dual_b;
					want_on_q    <= dual_a;
				end
				relay_pkg::MODE_OUT: begin
					zone_valid_q <= dual_a || dual_b;
					want_on_q    <= dual_b;
				end
				default: begin
					zone_valid_q <= 1'b0;
					want_on_q    <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// qualification and final relay state
	// ----------------------------------------
	assign fault = out_of_range;

	delay_qualifier #(
		.DW         (DW)
	) u_qual (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.tick       (tick),
		.zone_valid (zone_valid_q),
		.want_on    (want_on_q),
		.hold       (fault),
		.on_delay   (on_dly_q),
		.off_delay  (off_dly_q),
		.state_q    (qual_state)
	);

	// fault on wins even over a disabled relay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			relay_q <= 1'b0;
		end else if (fault && fresp == relay_pkg::FAULT_ON) begin
			relay_q <= 1'b1;
		end else if (fault && fresp == relay_pkg::FAULT_OFF) begin
			relay_q <= 1'b0;
		end else if (mode == relay_pkg::MODE_DISABLED) begin
			relay_q <= 1'b0;
		end else if (mode == relay_pkg::MODE_REMOTE) begin
			relay_q <= remote_cmd;
		end else if (!fault) begin
			relay_q <= qual_state;
		end
	end

	// unfitted relay: LED alone shows the condition
	assign relay_drive = relay_q && fitted;
	assign relay_led   = relay_q;

	assign status = {27'h0000000, zone_a_q, fault, showing_q,
	                 relay_led, relay_drive};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_peak;
		peak_found;
	endsequence

	sequence s_restart;
		showing_q && show_cnt_q == 16'h0000;
	endsequence

	AST_PEAK_SWING: assert property (@(posedge hclk)
		disable iff (!hresetn)
		peak_found |-> (hi_q - sample_value) >= swing_q)
		else $error("peak accepted without full swing");

	AST_PEAK_RESTART: assert property (@(posedge hclk)
		disable iff (!hresetn)
		s_peak |=> s_restart ##0 peak_q == $past(hi_q))
		else $error("new peak did not restart show timer");

	AST_SHOW_EXPIRE: assert property (@(posedge hclk)
		disable iff (!hresetn)
		showing_q && show_cnt_q >= show_per_q && !peak_found
		|=> !showing_q && shown_value == sample_value)
		else $error("held peak not released at expiry");

	AST_SOURCE: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!use_peak |-> cmp == sample_value)
		else $error("compared value not the live input");

	AST_LED: assert property (@(posedge hclk)
		disable iff (!hresetn)
		$rose(relay_q) |-> relay_led && (relay_drive == fitted))
		else $error("led or drive not following relay");

	AST_ZERO_DELAY: assert property (@(posedge hclk)
		disable iff (!hresetn)
		zone_valid_q && want_on_q != qual_state && !fault
		&& on_dly_q == '0 && off_dly_q == '0
		|=> qual_state == $past(want_on_q))
		else $error("zero delay did not switch at once");

	AST_DISABLED: assert property (@(posedge hclk)
		disable iff (!hresetn)
		mode == relay_pkg::MODE_DISABLED && !fault [*2]
		|-> !relay_q)
		else $error("disabled relay not off");

	AST_FAULT: assert property (@(posedge hclk)
		disable iff (!hresetn)
		fault && fresp == relay_pkg::FAULT_ON |=> relay_q)
		else $error("fault did not force relay on");

endmodule : peak_hold_relay_threshold_ctrl

// ==== core/relay_defs.svh ====
// register map, field positions, reset values and timing constants
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_THR1        8'h04
`define OFS_THR2        8'h08
`define OFS_BAND_HALFWIDTH        8'h0C
`define OFS_DELAY       8'h10
`define OFS_SWING       8'h14
`define OFS_SHOW        8'h18
`define OFS_STATUS      8'h1C
`define OFS_PEAK        8'h20
`define OFS_SHOWN       8'h24

// ----------------------------------------
// control register fields and the off delay field of the delay register
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_PEAK_BIT   3
`define CTRL_FAULT_LSB  4
`define CTRL_FAULT_MSB  5
`define CTRL_MIN_BIT    6
`define CTRL_CMD_BIT    7
`define CTRL_FIT_BIT    8
`define DLY_OFF_LSB     16

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CTRL        32'h0000_0100
`define RST_THR         16'h0000
`define RST_BAND_HALFWIDTH        10'h000
`define RST_DELAY       10'h000
`define RST_SWING       16'h000A
`define RST_SHOW        16'h0032

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS   100
`define TICK_PERIOD_NS  100000000
`define TENTHS_PER_MIN  60

`endif

// ==== core/relay_pkg.sv ====
// types shared by the relay threshold controller
package relay_pkg;

	typedef enum logic [2:0] {
		MODE_DISABLED = 3'h0,
		MODE_ON       = 3'h1,
		MODE_OFF      = 3'h2,
		MODE_IN       = 3'h3,
		MODE_OUT      = 3'h4,
		MODE_REMOTE   = 3'h5
	} relay_mode_e;

	typedef enum logic [1:0] {
		FAULT_KEEP = 2'h0,
		FAULT_ON   = 2'h1,
		FAULT_OFF  = 2'h2
	} fault_resp_e;

	typedef enum logic {
		PK_RISE = 1'b0,
		PK_FALL = 1'b1
	} peak_state_e;

endpackage : relay_pkg

// ==== tb/meas_stage_model.sv ====
// measurement stage model feeding samples and the range flag
`timescale 1ns/1ps

module meas_stage_model (
	// clock
	input  wire logic          hclk,
	// measurement stage
	output logic               sample_valid,
	output logic signed [15:0] sample_value,
	output logic               out_of_range
);
	initial begin
		sample_valid = 1'b0;
		sample_value = 16'sh0000;
		out_of_range = 1'b0;
	end

	// value stays put between pulses, the design reads it live
	task automatic send(input logic signed [15:0] v);
		sample_value <= v;
		sample_valid <= 1'b1;
		@(posedge hclk);
		sample_valid <= 1'b0;
		// one idle edge so back to back sends never touch valid twice
		@(posedge hclk);
	endtask : send

	task automatic set_range(input logic bad);
		out_of_range <= bad;
	endtask : set_range
endmodule : meas_stage_model

// ==== tb/tb_peak_hold_relay_threshold_ctrl.sv ====
// self-checking bench for the peak hold relay threshold controller
`timescale 1ns/1ps
`include "relay_defs.svh"

module tb_peak_hold_relay_threshold_ctrl;
	localparam int TICKS = 10;
	logic               hclk;
	logic               hresetn;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [2:0]         hsize;
	logic [31:0]        hwdata;
	logic               hready;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               hresp;
	logic               sample_valid;
	logic signed [15:0] sample_value;
	logic               out_of_range;
	logic               relay_drive;
	logic               relay_led;
	logic               peak_showing;
	logic signed [15:0] shown_value;
	int                 error_cnt;
	int                 check_count;

	assign hready = hreadyout;
	always #50 hclk = ~hclk;

	// ----------------------------------------
	// instances
	// ----------------------------------------
	peak_hold_relay_threshold_ctrl #(.TICK_CYCLES(TICKS))
	u_peak_hold_relay_threshold_ctrl (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hready),
		.hrdata       (hrdata),
		.hreadyout    (hreadyout),
		.hresp        (hresp),
		.sample_valid (sample_valid),
		.sample_value (sample_value),
		.out_of_range (out_of_range),
		.relay_drive  (relay_drive),
		.relay_led    (relay_led),
		.peak_showing (peak_showing),
		.shown_value  (shown_value)
	);

	meas_stage_model u_meas_stage_model (
		.hclk         (hclk),
		.sample_valid (sample_valid),
		.sample_value (sample_value),
		.out_of_range (out_of_range)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bounded wait; a slave that never answers ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_ready

	// idle cycle at the end: a read right behind a write sees old data
	task automatic bus(input logic wr_en, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr_en;
		htrans <= 2'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		cyc(1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, a, 32'h0, got);
		chk(got, exp);
	endtask : rd_chk

	// expected pair is {relay_drive, relay_led}
	task automatic rl(input logic [1:0] e);
		chk({30'h0, relay_drive, relay_led}, {30'h0, e});
	endtask : rl

	// zone lands at the sample edge, relay two edges later
	task automatic sc(input logic signed [15:0] v, input logic [1:0] e);
		u_meas_stage_model.send(v);
		cyc(2);
		rl(e);
	endtask : sc

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		error_cnt = 0;
		check_count = 0;
		cyc(16);
		hresetn <= 1'b1;
		cyc(1);
		rl(2'b00);
		chk({31'h0, hresp}, 32'h0);
		rd_chk(`OFS_CTRL, `RST_CTRL);
		rd_chk(`OFS_SWING, {16'h0, `RST_SWING});
		rd_chk(`OFS_SHOW, {16'h0, `RST_SHOW});
		rd_chk(`OFS_THR1, {16'h0, `RST_THR});
		rd_chk(`OFS_DELAY, 32'h0);
		rd_chk(8'h30, 32'h0);
		// peak hold drives the compared value
		wr(`OFS_SHOW, 32'h0000_0005);
		wr(`OFS_THR1, 32'h0000_0046);
		wr(`OFS_CTRL, 32'h0000_0109);
		sc(16'h0000, 2'b00);
		sc(16'h0005, 2'b00);
		sc(16'h0000, 2'b00);
		chk({31'h0, peak_showing}, 32'h0);
		sc(16'h0014, 2'b00);
		sc(16'h0032, 2'b00);
		sc(16'h0023, 2'b00);
		chk({31'h0, peak_showing}, 32'h1);
		chk({16'h0, shown_value}, 32'h0000_0032);
		cyc(26);
		sc(16'h0050, 2'b00);
		sc(16'h003C, 2'b00);
		sc(16'h003C, 2'b11);
		chk({16'h0, shown_value}, 32'h0000_0050);
		cyc(25);
		chk({31'h0, peak_showing}, 32'h1);
		cyc(60);
		chk({31'h0, peak_showing}, 32'h0);
		chk({16'h0, shown_value}, 32'h0000_003C);
		sc(16'h003C, 2'b00);
		// single threshold, zero delays
		wr(`OFS_THR1, 32'h0000_0064);
		wr(`OFS_BAND_HALFWIDTH, 32'h0000_000A);
		wr(`OFS_CTRL, 32'h0000_0100);
		sc(16'h006F, 2'b00);
		wr(`OFS_CTRL, 32'h0000_0101);
		sc(16'h006F, 2'b11);
		sc(16'h0069, 2'b11);
		sc(16'h0059, 2'b00);
		sc(16'h006E, 2'b00);
		wr(`OFS_CTRL, 32'h0000_0102);
		sc(16'h0059, 2'b11);
		sc(16'h006F, 2'b00);
		wr(`OFS_CTRL, 32'h0000_0001);
		sc(16'h006F, 2'b01);
		wr(`OFS_CTRL, 32'h0000_0185);
		sc(16'h0000, 2'b11);
		wr(`OFS_CTRL, 32'h0000_0105);
		sc(16'h006F, 2'b00);
		// dual threshold, second one negative and lower
		wr(`OFS_THR1, 32'h0000_00C8);
		wr(`OFS_THR2, 32'h0000_FFCE);
		rd_chk(`OFS_THR2, 32'hFFFF_FFCE);
		wr(`OFS_BAND_HALFWIDTH, 32'h0000_0005);
		wr(`OFS_CTRL, 32'h0000_0103);
		sc(16'h0096, 2'b11);
		sc(16'h00FA, 2'b00);
		sc(16'h0000, 2'b11);
		sc(16'hFF9C, 2'b00);
		wr(`OFS_CTRL, 32'h0000_0104);
		sc(16'hFF9C, 2'b11);
		sc(16'h0096, 2'b00);
		// qualification delays of three tenths
		wr(`OFS_CTRL, 32'h0000_0101);
		sc(16'h0000, 2'b00);
		wr(`OFS_DELAY, 32'h0003_0003);
		sc(16'h00FA, 2'b00);
		sc(16'h0000, 2'b00);
		cyc(60);
		rl(2'b00);
		sc(16'h00FA, 2'b00);
		cyc(23);
		rl(2'b00);
		cyc(60);
		rl(2'b11);
		sc(16'h0000, 2'b11);
		cyc(60);
		rl(2'b00);
		// minute unit: a tenth of a minute is sixty tenth-second ticks
		wr(`OFS_DELAY, 32'h0001_0001);
		wr(`OFS_CTRL, 32'h0000_0141);
		sc(16'h00FA, 2'b00);
		cyc(500);
		rl(2'b00);
		cyc(800);
		rl(2'b11);
		// out of range reactions
		wr(`OFS_DELAY, 32'h0);
		wr(`OFS_CTRL, 32'h0000_0110);
		u_meas_stage_model.set_range(1'b1);
		sc(16'h0000, 2'b11);
		rd_chk(`OFS_STATUS, 32'h0000_000F);
		rd_chk(`OFS_PEAK, 32'h0000_00FA);
		rd_chk(`OFS_SHOWN, 32'h0000_00FA);
		wr(`OFS_CTRL, 32'h0000_0121);
		sc(16'h01F4, 2'b00);
		wr(`OFS_CTRL, 32'h0000_0101);
		sc(16'h01F4, 2'b00);
		u_meas_stage_model.set_range(1'b0);
		sc(16'h01F4, 2'b11);
		// reset in mid-run drops the relay and the settings
		hresetn <= 1'b0;
		cyc(2);
		rl(2'b00);
		chk({31'h0, peak_showing}, 32'h0);
		hresetn <= 1'b1;
		cyc(1);
		rl(2'b00);
		rd_chk(`OFS_CTRL, `RST_CTRL);
		print_verdict();
	end
endmodule : tb_peak_hold_relay_threshold_ctrl
